// *** verilog/dram_mode_reg3_mpr_control.sv ***
// Purpose: mode register three decode and readout-mode read redirection
// Assumes: command pins sampled on clk, one command per cycle
// Notes: readout store contents come from outside on store_data, except page 2 location 0
`timescale 1ns/100ps
`include "mode_reg_three_map.svh"
module dram_mode_reg3_mpr_control #(
    parameter int unsigned TEMP_CYCLES = `TEMP_TS_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic act_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] bg,
    input wire logic [1:0] ba,
    input wire logic [17:0] addr,
    input wire logic sync_pulse,
    input wire logic device_selected,
    input wire logic [1:0] temp_sensor,
    input wire logic [7:0] store_data,
    output logic [21:0] mode_reg_three,
    output logic [1:0] read_format,
    output logic [2:0] wcl_clocks,
    output logic [2:0] refresh_gran,
    output logic [1:0] refresh_gran_fault,
    output logic [7:0] page2_loc0,
    output logic cmd_accept,
    output logic gear_quarter_rate,
    output logic store_access,
    output logic [1:0] store_page,
    output logic store_read,
    output logic [1:0] store_loc,
    output logic [7:0] store_rdata,
    output logic array_read
);
    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    logic mrs_cmd;
    logic rd_cmd;
    logic [21:0] mrs_word;
    logic hit;

    // mrs needs ras, cas and we low on an active, non-activate cycle
    // act_n high keeps an activate, whose row bits share these pins,
    // from ever being taken as a register write
    assign mrs_cmd = !cs_n && act_n && !ras_n && !cas_n && !we_n;

    // a read is cas low with ras and we high
    assign rd_cmd = !cs_n && act_n && ras_n && !cas_n && we_n;

    // word layout: group, bank, top row bit, three unused, low 14 pins
    // the unused bits 16:14 always read back as zero
    assign mrs_word = {bg, ba, addr[17], 3'h0, addr[13:0]};

    // per-device mode lets an unselected device ignore commands
    // the mask also covers the write that would clear the mask itself
    assign cmd_accept = !mode_reg_three[`MODE3_PDA_BIT] || device_selected;

    // only select code 011 lands here; other selects are other registers
    assign hit = mrs_cmd && cmd_accept
        && (mrs_word[`MODE3_SEL_HI:`MODE3_SEL_LO] == `MODE3_SEL_CODE);

    // ----------------------------------------------------------------
    // register and gear state
    // ----------------------------------------------------------------
    mode_reg_three_pkg::gear_state_t gear_state;
    mode_reg_three_pkg::gear_state_t next_gear_state;
    logic [21:0] next_mode_reg_three;

    // load the word on a matching mrs; reserved bits 21, 17 and 13 kept as written, 16:14 zero
    // writes are honoured in readout mode too, which is how it is left
    always_comb begin
        next_mode_reg_three = mode_reg_three;
        if (hit) begin
            next_mode_reg_three = mrs_word;
        end
        // gear-down entry is two steps: the mrs arms, the sync completes
        // leaving gear-down needs only the mrs, with no sync
        next_gear_state = gear_state;
        case (gear_state)
            mode_reg_three_pkg::gear_half: begin
                if (hit && mrs_word[`MODE3_GEAR_BIT]) begin
                    next_gear_state = mode_reg_three_pkg::gear_wait_sync;
                end
            end
            mode_reg_three_pkg::gear_wait_sync: begin
                // a clearing mrs before the sync cancels the entry
                if (hit && !mrs_word[`MODE3_GEAR_BIT]) begin
                    next_gear_state = mode_reg_three_pkg::gear_half;
                end else if (sync_pulse) begin
                    next_gear_state = mode_reg_three_pkg::gear_quarter;
                end
            end
            mode_reg_three_pkg::gear_quarter: begin
                if (hit && !mrs_word[`MODE3_GEAR_BIT]) begin
                    next_gear_state = mode_reg_three_pkg::gear_half;
                end
            end
            default: begin
                next_gear_state = mode_reg_three_pkg::gear_half;
            end
        endcase
    end

    // reset forces re-initialization, even in readout mode
    // readout access and gear-down both drop back to their start state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_reg_three <= `MODE3_RESET_VAL;
            gear_state <= mode_reg_three_pkg::gear_half;
        end else begin
            mode_reg_three <= next_mode_reg_three;
            gear_state <= next_gear_state;
        end
    end

    // ----------------------------------------------------------------
    // field outputs
    // ----------------------------------------------------------------
    // fields decoded straight from the register flops
    // reserved codes pass through unchanged; users must not rely on them
    assign read_format = mode_reg_three[`MODE3_FMT_HI:`MODE3_FMT_LO];

    // extra write latency: 4, 5 or 6 clocks; code 11 would show 7
    assign wcl_clocks = 3'(`WRLAT_BASE)
        + {1'h0, mode_reg_three[`MODE3_WRLAT_HI:`MODE3_WRLAT_LO]};

    assign refresh_gran = mode_reg_three[`MODE3_FGR_HI:`MODE3_FGR_LO];

    // flags any reserved granularity code
    // the upper bit is spare and held low
    assign refresh_gran_fault = {1'h0, !(refresh_gran == 3'h0 || refresh_gran == 3'h1
        || refresh_gran == 3'h2 || refresh_gran == 3'h5)};
    assign gear_quarter_rate = (gear_state == mode_reg_three_pkg::gear_quarter);

    // readout access and page come straight from their bits
    assign store_access = mode_reg_three[`MODE3_ACC_BIT];
    assign store_page = mode_reg_three[`MODE3_PAGE_HI:`MODE3_PAGE_LO];

    // ----------------------------------------------------------------
    // temperature status sampling
    // ----------------------------------------------------------------
    logic [31:0] temp_count;
    logic [31:0] next_temp_count;
    logic [7:0] next_page2_loc0;
    // resample the sensor well inside the age limit while enabled
    // the first sample follows the enabling write by one cycle, so a
    // read straight after enabling still sees the cleared zero status
    // a disabled status reads back as zero
    always_comb begin
        next_temp_count = temp_count;
        next_page2_loc0 = page2_loc0;
        if (!mode_reg_three[`MODE3_TSS_BIT]) begin
            next_temp_count = 32'h0;
            next_page2_loc0[4:3] = 2'h0;
        end else if (temp_count == 32'h0) begin
            next_page2_loc0[4:3] = temp_sensor;
            next_temp_count = TEMP_CYCLES - 32'h1;
        end else begin
            next_temp_count = temp_count - 32'h1;
        end
    end

    // sample counter and page 2 location 0 flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            temp_count <= 32'h0;
            page2_loc0 <= 8'h00;
        end else begin
            temp_count <= next_temp_count;
            page2_loc0 <= next_page2_loc0;
        end
    end

    // ----------------------------------------------------------------
    // read redirection
    // ----------------------------------------------------------------
    logic next_store_read;
    logic next_array_read;
    logic [1:0] next_store_loc;
    logic [7:0] next_store_rdata;
    // in readout mode every read goes to the addressed store location
    // page 2 location 0 is served from the local status byte, every
    // other location from the outside store, which is read the same cycle
    // outside readout mode a read goes on to the array as usual
    always_comb begin
        next_store_read = 1'h0;
        next_array_read = 1'h0;
        next_store_loc = store_loc;
        next_store_rdata = store_rdata;
        if (rd_cmd && cmd_accept) begin
            if (store_access) begin
                next_store_read = 1'h1;
                next_store_loc = addr[1:0];
                if (store_page == 2'h2 && addr[1:0] == 2'h0) begin
                    next_store_rdata = page2_loc0;
                end else begin
                    next_store_rdata = store_data;
                end
            end else begin
                next_array_read = 1'h1;
            end
        end
    end

    // read pulses last one cycle; location and data stand until the next
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            store_read <= 1'h0;
            array_read <= 1'h0;
            store_loc <= 2'h0;
            store_rdata <= 8'h00;
        end else begin
            store_read <= next_store_read;
            array_read <= next_array_read;
            store_loc <= next_store_loc;
            store_rdata <= next_store_rdata;
        end
    end
endmodule : dram_mode_reg3_mpr_control

// *** pkg/mode_reg_three_map.svh ***
// Purpose: constants for the mode register three block
// Assumes: one 200 MHz clock, 5 ns period
// Notes: offsets are bit positions of the 22-bit mode register word
`ifndef MODE_REG_THREE_MAP_SVH
`define MODE_REG_THREE_MAP_SVH
`define MODE3_SEL_HI 20
`define MODE3_SEL_LO 18
`define MODE3_SEL_CODE 3'h3
`define MODE3_FMT_HI 12
`define MODE3_FMT_LO 11
`define MODE3_WRLAT_HI 10
`define MODE3_WRLAT_LO 9
`define MODE3_FGR_HI 8
`define MODE3_FGR_LO 6
`define MODE3_TSS_BIT 5
`define MODE3_PDA_BIT 4
`define MODE3_GEAR_BIT 3
`define MODE3_ACC_BIT 2
`define MODE3_PAGE_HI 1
`define MODE3_PAGE_LO 0
`define MODE3_RESET_VAL 22'h000000
`define TEMP_TS_MS 32
`define CLK_MHZ 200
`define TEMP_TS_CYCLES (`TEMP_TS_MS * 1000 * `CLK_MHZ)
`define WRLAT_BASE 4
`endif

// *** pkg/mode_reg_three_pkg.sv ***
// Purpose: types for the mode register three block
// Assumes: nothing
// Notes: encodings of the register fields and of the gear-down states
package mode_reg_three_pkg;
    typedef enum logic [1:0] {
        fmt_serial = 2'h0,
        fmt_parallel = 2'h1,
        fmt_staggered = 2'h2,
        fmt_reserved = 2'h3
    } read_format_t;
    typedef enum logic [2:0] {
        fgr_fixed_1x = 3'h0,
        fgr_fixed_2x = 3'h1,
        fgr_fixed_4x = 3'h2,
        fgr_otf_1x_2x = 3'h5
    } refresh_gran_t;
    typedef enum logic [1:0] {
        gear_half = 2'h0,
        gear_wait_sync = 2'h1,
        gear_quarter = 2'h2
    } gear_state_t;
endpackage : mode_reg_three_pkg

// *** tb/dram_mode_reg3_mpr_control_assertions.sv ***
// Purpose: port-level checks of mode register three decode
// Assumes: one clock, async active-low reset
// Notes: bound into the design module
`timescale 1ns/100ps
module dram_mode_reg3_mpr_control_assertions (
    input wire logic clk, resetn, cs_n, act_n, ras_n, cas_n, we_n,
    input wire logic [1:0] bg, ba,
    input wire logic [17:0] addr,
    input wire logic sync_pulse, device_selected, cmd_accept, gear_quarter_rate,
    input wire logic [21:0] mode_reg_three,
    input wire logic [1:0] read_format, store_page, store_loc,
    input wire logic [2:0] wcl_clocks, refresh_gran,
    input wire logic [7:0] page2_loc0,
    input wire logic store_access, store_read, array_read
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // accepted command shapes
    sequence s_mrs;
        !cs_n && act_n && !ras_n && !cas_n && !we_n && cmd_accept;
    endsequence
    sequence s_rd;
        !cs_n && act_n && ras_n && !cas_n && we_n && cmd_accept;
    endsequence
    a_mrs_load: assert property (s_mrs ##0 ({bg[0], ba} == 3'h3) |=>
        mode_reg_three[13:0] == $past(addr[13:0])) else $error("register load wrong");
    a_other_sel: assert property (s_mrs ##0 ({bg[0], ba} != 3'h3) |=>
        $stable(mode_reg_three)) else $error("other select changed register");
    a_fmt_gran: assert property ({read_format, refresh_gran} ==
        {mode_reg_three[12:11], mode_reg_three[8:6]}) else $error("format or granularity wrong");
    a_wcl_map: assert property (wcl_clocks == 3'h4 + mode_reg_three[10:9])
        else $error("write latency wrong");
    a_page_map: assert property ({store_access, store_page} == mode_reg_three[2:0])
        else $error("readout page wrong");
    a_pda_mask: assert property (cmd_accept == (!mode_reg_three[4] || device_selected))
        else $error("command accept wrong");
    a_gear_sync: assert property ($rose(gear_quarter_rate) |->
        $past(sync_pulse) && mode_reg_three[3]) else $error("gear change without sync");
    a_store_read: assert property (s_rd ##0 store_access |=> store_read &&
        store_loc == $past(addr[1:0])) else $error("readout read wrong");
    a_array_read: assert property (s_rd ##0 !store_access |=> array_read && !store_read)
        else $error("array read wrong");
    a_temp_clear: assert property (!mode_reg_three[5] [*2] |-> page2_loc0 == 8'h00)
        else $error("temperature status not clear");
endmodule : dram_mode_reg3_mpr_control_assertions
bind dram_mode_reg3_mpr_control dram_mode_reg3_mpr_control_assertions u_chk (.*);

// *** tb/mrs_ctrl_model.sv ***
// Purpose: controller side driving command and address pins
// Assumes: commands launched on the falling edge
// Notes: only MRS and RD are issued, never refresh or power-down
`timescale 1ns/100ps
module mrs_ctrl_model (
    input wire logic clk,
    output logic cs_n, act_n, ras_n, cas_n, we_n,
    output logic [1:0] bg, ba,
    output logic [17:0] addr
);
    initial {cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr} = 27'h7C00000;
    // one command for one cycle, bits 21, 17 and 13 forced clear, pins 16:14 driven to 101
    task cmd(input logic rd, input logic [21:0] w);
        @(negedge clk);
        {cs_n, ras_n, cas_n, we_n} = {1'b0, rd, 1'b0, rd};
        {bg, ba, addr[17]} = w[21:17] & 5'h0E;
        addr[16:0] = {3'h5, 1'b0, w[12:0]};
    endtask : cmd
    // deselect; released lines show the inverse of the last value
    task idle();
        @(negedge clk);
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        {bg, ba, addr} = ~{bg, ba, addr};
    endtask : idle
endmodule : mrs_ctrl_model

// *** tb/dram_mode_reg3_mpr_control_test.sv ***
// Purpose: self-checking bench for mode register three decode
// Assumes: 200 MHz clock, temperature interval shortened to 20
// Notes: random field writes plus readout, masking, gear and reset cases
`timescale 1ns/100ps
module dram_mode_reg3_mpr_control_test;
    logic clk, resetn, cs_n, act_n, ras_n, cas_n, we_n, sync_pulse, device_selected;
    logic [1:0] bg, ba, temp_sensor, read_format, refresh_gran_fault, store_page, store_loc;
    logic [17:0] addr;
    logic [7:0] store_data, page2_loc0, store_rdata;
    logic [21:0] mode_reg_three, w, e;
    logic [2:0] wcl_clocks, refresh_gran;
    logic cmd_accept, gear_quarter_rate, store_access, store_read, array_read;
    int bad_count, cmp_count, cyc;
    logic [2:0] fgr_tbl [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
    dram_mode_reg3_mpr_control #(.TEMP_CYCLES(20)) u_dram_mode_reg3_mpr_control (.*);
    mrs_ctrl_model u_mrs_ctrl_model (.*);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            finish_test();
        end
    end
    task chk(input string n, input logic [21:0] ex, input logic [21:0] got);
        cmp_count++;
        if (got !== ex) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", n, ex, got);
        end
    endtask : chk
    task mrs(input logic [21:0] v);
        u_mrs_ctrl_model.cmd(1'b0, v);
        u_mrs_ctrl_model.idle();
    endtask : mrs
    task rd(input logic [1:0] loc);
        u_mrs_ctrl_model.cmd(1'b1, {20'h00000, loc});
        u_mrs_ctrl_model.idle();
    endtask : rd
    // stored word: target select set to 011, reserved bits clear
    function automatic logic [21:0] stored_word(input logic [21:0] v);
        return {1'b0, 3'h3, 5'h00, v[12:0]};
    endfunction : stored_word
    task finish_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        resetn = 1'b0;
        {sync_pulse, device_selected, temp_sensor, store_data} = 12'h000;
        void'($urandom(3383));
        repeat (12) @(negedge clk);
        chk("reset word", 22'h000000, mode_reg_three);
        chk("reset wcl", 22'h4, wcl_clocks);
        resetn = 1'b1;
        for (int i = 0; i < 24; i++) begin
            w = 22'($urandom);
            w[12:6] = {2'(i % 3), 2'(i % 3), fgr_tbl[i % 4]};
            {w[20:18], w[4]} = 4'h6;
            e = stored_word(w);
            mrs(w);
            chk("word", e, mode_reg_three);
            chk("format", e[12:11], read_format);
            chk("wcl", 22'h4 + e[10:9], wcl_clocks);
            chk("gran", e[8:6], refresh_gran);
            chk("gran fault", 22'h0, refresh_gran_fault);
            chk("page", e[2:0], {store_access, store_page});
            w[20:18] = 3'h3 ^ (3'h1 + 3'(i % 7));
            mrs(w);
            chk("other select", e, mode_reg_three);
        end
        $display("test fields done");
        mrs(stored_word(22'h000005));
        for (int i = 0; i < 4; i++) begin
            store_data = 8'($urandom);
            rd(2'(i));
            chk("store read", 22'h1, store_read);
            chk("store data", store_data, store_rdata);
            chk("store loc", 22'(i), store_loc);
        end
        mrs(stored_word(22'h000000));
        rd(2'h1);
        chk("array read", 22'h1, {store_read, array_read});
        temp_sensor = 2'($urandom);
        mrs(stored_word(22'h000026));
        repeat (25) @(negedge clk);
        rd(2'h0);
        chk("temp status", 22'(temp_sensor) << 3, store_rdata);
        $display("test readout done");
        device_selected = 1'b1;
        mrs(stored_word(22'h000010));
        device_selected = 1'b0;
        mrs(stored_word(22'h000000));
        chk("masked accept", 22'h0, cmd_accept);
        chk("masked write", stored_word(22'h000010), mode_reg_three);
        device_selected = 1'b1;
        mrs(stored_word(22'h000008));
        @(negedge clk);
        chk("gear before sync", 22'h0, gear_quarter_rate);
        sync_pulse = 1'b1;
        @(negedge clk);
        sync_pulse = 1'b0;
        chk("gear after sync", 22'h1, gear_quarter_rate);
        mrs(stored_word(22'h000004));
        resetn = 1'b0;
        @(negedge clk);
        chk("reset in readout", 22'h0, {store_access, mode_reg_three[20:0]});
        $display("test modes done");
        finish_test();
    end
endmodule : dram_mode_reg3_mpr_control_test
